// file: include/sfp_regs.vh
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

`define SFP_ADDR_W        24
`define SFP_SECT_W        6
`define SFP_SUB_W         5
`define SFP_SECT_LSB      16
`define SFP_SUB_LSB       12
`define SFP_SUB_SPAN_LSB  17
`define SFP_SUB_BOTTOM    7'h00
`define SFP_SUB_TOP       7'h1f
`define SFP_CFG_QUAD      1
`define SFP_CFG_PARAMLOC  2
`define SFP_CFG_RESET     8'h00
`define SFP_BYTE_W        8
`define SFP_BITCNT_W      3
`define SFP_BITCNT_LAST   3'h7
`define SFP_PAGE_W        8
`define SFP_PAGE_DEPTH    256
`define SFP_ERASED        8'hff
`define SFP_OP_IDLE       2'h0
`define SFP_OP_PROGRAM    2'h1
`define SFP_OP_ERASE      2'h2
`define SFP_OP_SETTLE     2'h3
`define SFP_ER_SUB        2'h0
`define SFP_ER_SECT       2'h1
`define SFP_ER_ARRAY      2'h2
`define SFP_PROG_CYCLES   16'h0400
`define SFP_PROG_CYC_ACC  16'h0100
`define SFP_ERASE_CYCLES  16'h2000

`endif

// file: rtl/sfp_sector_map.v
`timescale 1ns/1ps
`default_nettype none
`include "sfp_regs.vh"

module sfp_sector_map
(
   input  wire [`SFP_ADDR_W-1:0] addr,
   input  wire                   paramTop,
   output wire [`SFP_SECT_W-1:0] mainSector,
   output wire                   inSubArea,
   output wire [`SFP_SUB_W-1:0]  subSector
);

   wire [`SFP_ADDR_W-`SFP_SUB_SPAN_LSB-1:0] spanTag;

   assign mainSector = addr[`SFP_SECT_LSB +: `SFP_SECT_W];
   assign spanTag    = addr[`SFP_ADDR_W-1:`SFP_SUB_SPAN_LSB];
   // lowest or highest 128 KB split into 32 x 4 KB
   assign inSubArea  = paramTop ? (spanTag == `SFP_SUB_TOP) : (spanTag == `SFP_SUB_BOTTOM);
   assign subSector  = addr[`SFP_SUB_LSB +: `SFP_SUB_W];

endmodule
`default_nettype wire

// file: rtl/sfp_serial_flash_core.v
// Operation
// - pause stops serial traffic; running internal jobs continue to completion
// - pause falling with serial clock low enters paused state at once
// - pause falling with clock high waits for next clock falling edge
// - pause rising with serial clock low leaves paused state at once
// - pause rising with clock high stays paused until next clock falling edge
// - while paused, data output floats; data input and clock ignored
// - select high while paused resets interface and drops command state
// - quad configuration disables the pause input entirely
// - high voltage on protect pin shortens programs, except in quad mode
// - program data gathered in page buffer before array commit
// - program only clears bits, byte or whole page
// - erase sets bits for sub-sector, 64 KB sector or whole array
// - decode 64 sectors of 64 KB; lowest 128 KB as 32 x 4 KB
// - location bit 2 puts sub-sectors at top when set, bottom by default
// - quad bit 1 selects four-wire data mode when set
// - inputs sampled on clock rising edge, msb first, after select falls
`timescale 1ns/1ps
`default_nettype none
`include "sfp_regs.vh"

module sfp_serial_flash_core
(
   input  wire                   clk,
   input  wire                   rst,
   input  wire                   selectN,
   input  wire                   serialClk,
   input  wire                   serialIn,
   input  wire                   pauseN,
   input  wire                   accelerationHighVoltage,
   input  wire [`SFP_BYTE_W-1:0] cfgIn,
   input  wire                   cfgLoad,
   input  wire                   jobProgram,
   input  wire                   jobErase,
   input  wire [1:0]             jobEraseScope,
   input  wire [`SFP_ADDR_W-1:0] jobAddr,
   input  wire                   jobWholePage,
   input  wire [`SFP_BYTE_W-1:0] arrayRdData,
   output reg                    serialOut,
   output reg                    serialOutEn,
   output reg  [`SFP_BYTE_W-1:0] rxByte,
   output reg                    rxByteValid,
   output reg                    paused,
   output reg                    quadMode,
   output reg                    busy,
   output reg                    arrayWrEn,
   output reg  [`SFP_ADDR_W-1:0] arrayWrAddr,
   output reg  [`SFP_BYTE_W-1:0] arrayWrData,
   output reg                    eraseEn,
   output reg  [1:0]             eraseScope,
   output reg  [`SFP_SECT_W-1:0] eraseSector,
   output reg                    eraseSubArea,
   output reg  [`SFP_SUB_W-1:0]  eraseSub,
   output reg                    programAcceleration
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   reg [3:0] syncA_reg;
   reg [3:0] syncB_reg;
   reg       sckOld_reg;
   reg       pauseOld_reg;
   reg       selOld_reg;
   wire      selNs    = syncB_reg[0];
   wire      sckS     = syncB_reg[1];
   wire      sinS     = syncB_reg[2];
   wire      pauseNs  = syncB_reg[3];
   wire      sckRise  = sckS & ~sckOld_reg;
   wire      sckFall  = ~sckS & sckOld_reg;
   wire      pauseFall = ~pauseNs & pauseOld_reg;
   wire      pauseRise = pauseNs & ~pauseOld_reg;
   wire      selFall  = ~selNs & selOld_reg;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         syncA_reg    <= 4'hd;
         syncB_reg    <= 4'hd;
         sckOld_reg   <= 1'b0;
         pauseOld_reg <= 1'b1;
         selOld_reg   <= 1'b1;
      end
      else
      begin
         syncA_reg    <= {pauseN, serialIn, serialClk, selectN};
         syncB_reg    <= syncA_reg;
         sckOld_reg   <= sckS;
         pauseOld_reg <= pauseNs;
         selOld_reg   <= selNs;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration
   reg [`SFP_BYTE_W-1:0] cfg_reg;
   wire quadCfg  = cfg_reg[`SFP_CFG_QUAD];
   wire paramTop = cfg_reg[`SFP_CFG_PARAMLOC];

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         cfg_reg <= `SFP_CFG_RESET;
      else if (cfgLoad)
         cfg_reg <= cfgIn;
   end

   always @*
   begin
      quadMode = quadCfg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pause state; edges seen with clock low act at once, else defer
   reg pendEnter_reg;
   reg pendLeave_reg;
   reg paused_next;
   reg pendEnter_next;
   reg pendLeave_next;
   always @*
   begin
      paused_next    = paused;
      pendEnter_next = pendEnter_reg;
      pendLeave_next = pendLeave_reg;
      if (quadCfg || selNs)
      begin
         paused_next    = 1'b0;
         pendEnter_next = 1'b0;
         pendLeave_next = 1'b0;
      end
      else if (pauseFall || pauseRise)
      begin
         pendEnter_next = pauseFall & sckS;
         pendLeave_next = pauseRise & sckS;
         if (!sckS)
            paused_next = pauseFall;
      end
      else if (sckFall && (pendEnter_reg || pendLeave_reg))
      begin
         paused_next    = pendEnter_reg;
         pendEnter_next = 1'b0;
         pendLeave_next = 1'b0;
      end
   end
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         paused        <= 1'b0;
         pendEnter_reg <= 1'b0;
         pendLeave_reg <= 1'b0;
      end
      else
      begin
         paused        <= paused_next;
         pendEnter_reg <= pendEnter_next;
         pendLeave_reg <= pendLeave_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial shifter; frozen while paused so a resume continues mid-byte
   reg [`SFP_BITCNT_W-1:0] bitCnt_reg;
   reg [`SFP_BYTE_W-1:0]   shift_reg;
   reg [`SFP_BYTE_W-1:0]   txShift_reg;
   wire                    linkActive = ~selNs & ~paused;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bitCnt_reg  <= {`SFP_BITCNT_W{1'b0}};
         shift_reg   <= {`SFP_BYTE_W{1'b0}};
         txShift_reg <= {`SFP_BYTE_W{1'b0}};
         rxByte      <= {`SFP_BYTE_W{1'b0}};
         rxByteValid <= 1'b0;
         serialOut   <= 1'b0;
         serialOutEn <= 1'b0;
      end
      else
      begin
         rxByteValid <= 1'b0;
         // follows the next pause state so the output never drives in a paused cycle
         serialOutEn <= ~selNs & ~paused_next;
         if (selNs || selFall)
         begin
            bitCnt_reg <= {`SFP_BITCNT_W{1'b0}};
            shift_reg  <= {`SFP_BYTE_W{1'b0}};
         end
         else if (linkActive && sckRise)
         begin
            shift_reg  <= {shift_reg[`SFP_BYTE_W-2:0], sinS};
            bitCnt_reg <= bitCnt_reg + 1'b1;
            if (bitCnt_reg == `SFP_BITCNT_LAST)
            begin
               rxByte      <= {shift_reg[`SFP_BYTE_W-2:0], sinS};
               rxByteValid <= 1'b1;
            end
         end
         else if (linkActive && sckFall)
         begin
            serialOut   <= txShift_reg[`SFP_BYTE_W-1];
            txShift_reg <= {txShift_reg[`SFP_BYTE_W-2:0], txShift_reg[`SFP_BYTE_W-1]};
         end
         // reply loads only while the link runs, so a pause holds it
         if (linkActive && rxByteValid)
            txShift_reg <= rxByte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page buffer and internal job engine; never touched by pause
   reg [`SFP_BYTE_W-1:0]   pageMem [0:`SFP_PAGE_DEPTH-1];
   reg [`SFP_PAGE_W-1:0]   fillPtr_reg;
   reg [`SFP_PAGE_W-1:0]   jobPtr_reg;
   reg [1:0]               op_reg;
   reg [15:0]              timer_reg;
   reg [`SFP_ADDR_W-1:0]   jobBase_reg;
   reg                     jobPage_reg;
   reg                     dataPhase_reg;
   wire [`SFP_SECT_W-1:0]  mapSect;
   wire                    mapInSub;
   wire [`SFP_SUB_W-1:0]   mapSub;
   localparam [1:0]        OP_IDLE    = `SFP_OP_IDLE;
   localparam [1:0]        OP_PROGRAM = `SFP_OP_PROGRAM;
   localparam [1:0]        OP_ERASE   = `SFP_OP_ERASE;
   localparam [1:0]        OP_SETTLE  = `SFP_OP_SETTLE;

   sfp_sector_map mapper
   (
      .addr       (jobAddr),
      .paramTop   (paramTop),
      .mainSector (mapSect),
      .inSubArea  (mapInSub),
      .subSector  (mapSub)
   );
   always @(posedge clk)
   begin
      if (rxByteValid && op_reg == OP_IDLE)
         pageMem[fillPtr_reg] <= rxByte;
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fillPtr_reg  <= {`SFP_PAGE_W{1'b0}};
         jobPtr_reg   <= {`SFP_PAGE_W{1'b0}};
         op_reg       <= OP_IDLE;
         timer_reg    <= 16'h0000;
         jobBase_reg  <= {`SFP_ADDR_W{1'b0}};
         jobPage_reg  <= 1'b0;
         dataPhase_reg <= 1'b0;
         busy         <= 1'b0;
         arrayWrEn    <= 1'b0;
         arrayWrAddr  <= {`SFP_ADDR_W{1'b0}};
         arrayWrData  <= `SFP_ERASED;
         eraseEn      <= 1'b0;
         eraseScope   <= `SFP_ER_SUB;
         eraseSector  <= {`SFP_SECT_W{1'b0}};
         eraseSubArea <= 1'b0;
         eraseSub     <= {`SFP_SUB_W{1'b0}};
         programAcceleration <= 1'b0;
      end
      else
      begin
         arrayWrEn <= 1'b0;
         eraseEn   <= 1'b0;
         if (selFall)
            fillPtr_reg <= {`SFP_PAGE_W{1'b0}};
         else if (rxByteValid && op_reg == OP_IDLE)
            fillPtr_reg <= fillPtr_reg + 1'b1;
         case (op_reg)
            OP_IDLE:
            begin
               busy <= 1'b0;
               if (jobProgram)
               begin
                  op_reg      <= OP_PROGRAM;
                  busy        <= 1'b1;
                  jobBase_reg <= jobAddr;
                  jobPage_reg <= jobWholePage;
                  jobPtr_reg  <= {`SFP_PAGE_W{1'b0}};
                  dataPhase_reg <= 1'b0;
                  // high voltage shortens program, not in quad mode
                  programAcceleration <= accelerationHighVoltage & ~quadCfg;
                  timer_reg   <= (accelerationHighVoltage & ~quadCfg) ? `SFP_PROG_CYC_ACC
                                                                      : `SFP_PROG_CYCLES;
               end
               else if (jobErase)
               begin
                  op_reg       <= OP_ERASE;
                  busy         <= 1'b1;
                  timer_reg    <= `SFP_ERASE_CYCLES;
                  eraseScope   <= jobEraseScope;
                  eraseSector  <= mapSect;
                  eraseSubArea <= mapInSub;
                  eraseSub     <= mapSub;
               end
            end
            OP_PROGRAM:
            begin
               if (!dataPhase_reg)
               begin
                  arrayWrAddr   <= {jobBase_reg[`SFP_ADDR_W-1:`SFP_PAGE_W],
                                    jobBase_reg[`SFP_PAGE_W-1:0] + jobPtr_reg};
                  dataPhase_reg <= 1'b1;
               end
               else
               begin
                  // only 1 to 0: and with current array contents
                  arrayWrData   <= pageMem[jobPtr_reg] & arrayRdData;
                  arrayWrEn     <= 1'b1;
                  dataPhase_reg <= 1'b0;
                  jobPtr_reg    <= jobPtr_reg + 1'b1;
                  if (!jobPage_reg || jobPtr_reg + 1'b1 == fillPtr_reg)
                     op_reg <= OP_SETTLE;
               end
            end
            default:
            begin
               // erase wait or program settle; settle shortened under acceleration
               if (timer_reg == 16'h0000)
               begin
                  eraseEn <= (op_reg == OP_ERASE);
                  op_reg  <= OP_IDLE;
                  programAcceleration <= 1'b0;
               end
               else
                  timer_reg <= timer_reg - 1'b1;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// file: sim/sfp_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_core_monitor
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       selectN,
   input wire logic       pauseN,
   input wire logic       accelerationHighVoltage,
   input wire logic [7:0] arrayRdData,
   input wire logic       serialOutEn,
   input wire logic       rxByteValid,
   input wire logic       paused,
   input wire logic       quadMode,
   input wire logic       busy,
   input wire logic       arrayWrEn,
   input wire logic [7:0] arrayWrData,
   input wire logic       eraseEn,
   input wire logic       programAcceleration
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   pause_float_a: assert property (paused |-> !serialOutEn)
      else $error("data output driven while paused");
   pause_no_rx_a: assert property (paused |-> !rxByteValid)
      else $error("byte completed while paused");
   quad_no_pause_a: assert property (quadMode |-> !paused)
      else $error("paused in quad mode");
   quad_no_accel_a: assert property (quadMode |-> !programAcceleration)
      else $error("acceleration in quad mode");
   accel_cause_a: assert property ($rose(programAcceleration) |-> accelerationHighVoltage && busy)
      else $error("acceleration without high voltage or job");
   clear_only_a: assert property (arrayWrEn |-> (arrayWrData & ~arrayRdData) == 8'h00)
      else $error("program sets a bit");
   write_in_job_a: assert property (arrayWrEn |-> busy)
      else $error("array write outside a job");
   erase_end_a: assert property (eraseEn |=> !busy)
      else $error("busy stays after erase");
   pause_select_a: assert property ($rose(paused) |-> !selectN)
      else $error("paused while deselected");
   resume_cause_a: assert property ($fell(paused) |-> pauseN || selectN)
      else $error("pause left with pause input low");
   rx_pulse_a: assert property (rxByteValid |=> !rxByteValid)
      else $error("byte strobe longer than one cycle");

   cover property ($rose(paused));
   cover property (arrayWrEn && programAcceleration);
   cover property (eraseEn);
endmodule

bind sfp_serial_flash_core sfp_core_monitor mon (.clk(clk), .rst(rst), .selectN(selectN), .pauseN(pauseN),
   .accelerationHighVoltage(accelerationHighVoltage), .arrayRdData(arrayRdData), .serialOutEn(serialOutEn),
   .rxByteValid(rxByteValid), .paused(paused), .quadMode(quadMode), .busy(busy), .arrayWrEn(arrayWrEn),
   .arrayWrData(arrayWrData), .eraseEn(eraseEn), .programAcceleration(programAcceleration));

`default_nettype wire

// file: sim/sfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_host_model
(
   input  wire logic clk,
   output logic      selectN,
   output logic      serialClk,
   output logic      serialIn,
   output logic      pauseN
);
   // clock idles low and stands still outside frames
   initial
   begin
      selectN = 1'b1;
      serialClk = 1'b0;
      serialIn = 1'b0;
      pauseN = 1'b1;
   end

   task automatic edgeTo(input logic s);
   begin
      repeat (4) @(negedge clk);
      serialClk = s;
   end
   endtask

   // data set while clock is low, held across the rising edge
   task automatic bitRise(input logic b);
   begin
      @(negedge clk);
      serialIn = b;
      edgeTo(1'b1);
   end
   endtask

   task automatic sendBits(input logic [7:0] data, input int hi, input int lo);
   begin
      for (int i = hi; i >= lo; i--)
      begin
         bitRise(data[i]);
         edgeTo(1'b0);
      end
      // stale data would hide a late sample
      serialIn = ~serialIn;
   end
   endtask

   // sel 1 moves select, 0 moves pause; bench orders them to keep state
   task automatic setPin(input logic sel, input logic v);
   begin
      @(negedge clk);
      if (sel)
         selectN = v;
      else
         pauseN = v;
      repeat (8) @(negedge clk);
   end
   endtask
endmodule

`default_nettype wire

// file: sim/sfp_serial_flash_core_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_serial_flash_core_bench;
   logic        clk, rst, accHv, cfgLoad, jobProgram, jobErase, wholePage, accelSeen;
   logic [7:0]  cfgIn, rdData, b, j, wrDataQ;
   logic [1:0]  jobScope;
   logic [23:0] jobAddr, a, wrAddrQ;
   logic [13:0] erSeen;
   logic [7:0]  rxQ[$];
   int          mismatches, checkCount, cycles, busyCycles, wrCount, erCount;
   wire         selectN, serialClk, serialIn, pauseN, outEn, rxValid, paused, quadMode, busy;
   wire         wrEn, eraseEn, subArea, accel, serialOut;
   wire  [7:0]  rxByte, wrData;
   wire  [23:0] wrAddr;
   wire  [1:0]  erScope;
   wire  [5:0]  erSector;
   wire  [4:0]  erSub;

   sfp_host_model host (.clk(clk), .selectN(selectN), .serialClk(serialClk), .serialIn(serialIn), .pauseN(pauseN));
   sfp_serial_flash_core dut (.clk(clk), .rst(rst), .selectN(selectN), .serialClk(serialClk), .serialIn(serialIn),
      .pauseN(pauseN), .accelerationHighVoltage(accHv), .cfgIn(cfgIn), .cfgLoad(cfgLoad), .jobProgram(jobProgram),
      .jobErase(jobErase), .jobEraseScope(jobScope), .jobAddr(jobAddr), .jobWholePage(wholePage),
      .arrayRdData(rdData), .serialOut(serialOut), .serialOutEn(outEn), .rxByte(rxByte), .rxByteValid(rxValid),
      .paused(paused), .quadMode(quadMode), .busy(busy), .arrayWrEn(wrEn), .arrayWrAddr(wrAddr),
      .arrayWrData(wrData), .eraseEn(eraseEn), .eraseScope(erScope), .eraseSector(erSector),
      .eraseSubArea(subArea), .eraseSub(erSub), .programAcceleration(accel));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cycles++;
      if (rxValid === 1'b1)
         rxQ.push_back(rxByte);
      if (busy === 1'b1)
         busyCycles++;
      if (accel === 1'b1)
         accelSeen = 1'b1;
      if (wrEn === 1'b1)
      begin
         wrCount++;
         wrDataQ = wrData;
         wrAddrQ = wrAddr;
      end
      if (eraseEn === 1'b1)
      begin
         erCount++;
         erSeen = {erScope, erSector, subArea, erSub};
      end
      if (cycles == 50000)
      begin
         mismatches++;
         finishTest;
      end
   end

   function automatic logic [11:0] expMap(input logic [23:0] ad, input logic top);
      expMap = {ad[21:16], ad[21:17] == (top ? 5'h1f : 5'h00), ad[16:12]};
   endfunction

   task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
   begin
      checkCount++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   end
   endtask

   task automatic checkRx(input logic [7:0] exp);
   begin
      repeat (6) @(negedge clk);
      checkVal(rxQ.size(), 1);
      if (rxQ.size() > 0)
         checkVal({rxQ.pop_front(), serialOut}, {exp, exp[7]});
      rxQ.delete();
   end
   endtask

   task automatic loadCfg(input logic [7:0] v);
   begin
      @(negedge clk);
      cfgIn = v;
      cfgLoad = 1'b1;
      @(negedge clk);
      cfgLoad = 1'b0;
   end
   endtask

   task automatic runJob(input logic prog, input logic [1:0] scope, input logic [23:0] ad);
      int n;
   begin
      @(negedge clk);
      {jobAddr, jobScope, jobProgram, jobErase} = {ad, scope, prog, ~prog};
      {busyCycles, wrCount, erCount, accelSeen} = '0;
      @(negedge clk);
      {jobProgram, jobErase} = 2'b00;
      n = 0;
      while (busy !== 1'b0 && n < 10000)
      begin
         @(negedge clk);
         n++;
      end
      checkVal(busy, 0);
   end
   endtask

   task automatic finishTest;
   begin
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst, accHv, cfgLoad, jobProgram, jobErase, wholePage} = 6'h20;
      {cfgIn, rdData, jobScope, jobAddr} = '0;
      {mismatches, checkCount, cycles} = '0;
      void'($urandom(32'hfc2f));
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      checkVal({paused, busy, quadMode, outEn, wrData}, 12'h0ff);
      host.setPin(1'b1, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
         b = $urandom;
         host.sendBits(b, 7, 0);
         checkRx(b);
      end
      $display("test serial bytes done");
      b = $urandom;
      j = $urandom;
      host.sendBits(b, 7, 4);
      host.setPin(1'b0, 1'b0);
      checkVal(paused, 1);
      checkVal(outEn, 0);
      host.sendBits(j, 7, 4);
      host.setPin(1'b0, 1'b1);
      checkVal(paused, 0);
      host.sendBits(b, 3, 0);
      checkRx(b);
      b = $urandom;
      host.sendBits(b, 7, 5);
      host.bitRise(b[4]);
      host.setPin(1'b0, 1'b0);
      checkVal(paused, 0);
      host.edgeTo(1'b0);
      repeat (6) @(negedge clk);
      checkVal(paused, 1);
      host.edgeTo(1'b1);
      host.setPin(1'b0, 1'b1);
      checkVal(paused, 1);
      host.edgeTo(1'b0);
      repeat (6) @(negedge clk);
      checkVal(paused, 0);
      host.sendBits(b, 3, 0);
      checkRx(b);
      $display("test pause entry and exit done");
      host.sendBits(j, 7, 4);
      host.setPin(1'b0, 1'b0);
      host.setPin(1'b1, 1'b1);
      checkVal(paused, 0);
      host.setPin(1'b0, 1'b1);
      host.setPin(1'b1, 1'b0);
      b = $urandom;
      host.sendBits(b, 7, 0);
      checkRx(b);
      host.setPin(1'b1, 1'b1);
      $display("test deselect in pause done");
      rdData = $urandom;
      a = {$urandom, 8'h00} & 24'h3fff00;
      runJob(1'b1, 2'h0, a);
      checkVal({wrCount, wrAddrQ}, {32'd1, a});
      checkVal(wrDataQ, b & rdData);
      checkVal(busyCycles >= 1024, 1);
      accHv = 1'b1;
      wholePage = 1'b1;
      host.setPin(1'b1, 1'b0);
      b = $urandom;
      host.sendBits(j, 7, 0);
      host.sendBits(b, 7, 0);
      fork
         runJob(1'b1, 2'h0, a);
         begin
            repeat (20) @(negedge clk);
            host.setPin(1'b0, 1'b0);
         end
      join
      checkVal({paused, wrDataQ}, {1'b1, b & rdData});
      checkVal({wrCount[7:0], wrAddrQ}, {8'd2, a[23:8], 8'h01});
      checkVal(accelSeen && busyCycles < 1024, 1);
      host.setPin(1'b0, 1'b1);
      host.setPin(1'b1, 1'b1);
      wholePage = 1'b0;
      $display("test program done");
      loadCfg(8'h02);
      checkVal(quadMode, 1);
      host.setPin(1'b1, 1'b0);
      host.setPin(1'b0, 1'b0);
      checkVal(paused, 0);
      host.setPin(1'b0, 1'b1);
      host.setPin(1'b1, 1'b1);
      runJob(1'b1, 2'h0, a);
      checkVal(!accelSeen && busyCycles >= 1024, 1);
      accHv = 1'b0;
      $display("test quad mode done");
      for (int i = 0; i < 4; i++)
      begin
         loadCfg(i == 3 ? 8'h04 : 8'h00);
         a = $urandom;
         a[23:17] = (i == 3) ? 7'h1f : ((i == 0) ? 7'h00 : a[23:17] & 7'h1f);
         runJob(1'b0, (i == 3) ? 2'h0 : i[1:0], a);
         checkVal({erCount, erSeen[13:12]}, {32'd1, (i == 3) ? 2'h0 : i[1:0]});
         if (i != 2)
            checkVal(erSeen[11:0], expMap(a, i == 3));
      end
      $display("test erase and sector map done");
      finishTest;
   end
endmodule

`default_nettype wire
